// *** common/sosr_pkg.sv ***
// Purpose: Constants and types for the safety output status and reset block.
// Assumes: 25 MHz core clock, three safety outputs, eight safety inputs.
// Notes:   All timing counts derive from times in their own unit.
// What this block does
// R1: Line one shows configuration name when confirmed, else a not-confirmed code.
// R2: Lines two to four each show one safety output state.
// R3: Marker steps through off outputs only, every two seconds.
// R4: Line five reports the cause for the marked output.
// R5: Output state is one of seven values; delays finish when timers expire.
// R6: Reset-needed output shows which manual reset input to press.
// R7: Monitoring contact fault names the monitoring input on line five.
// R8: Output fault clears on system reset without power cycle.
// R9: Off or off-delay output shows the input holding it off.
// R10: Several inputs rotate; up freezes, down advances at once.
// R11: Stop input forces its mapped outputs off.
// R12: Start-up test input holds output off until run-stop-run.
// R13: Deactivated two-hand or enabling input blocks turn-on until run-stop-run.
// R14: Enable time limit turns output off; cycling or release plus reset recovers.
// R15: Valve monitoring test holds output off, then turns it on.
// R16: Output on shows inputs only if mapped input muted, bypassed or faulted.
// R17: Line five reports mute lamp fault when lamp circuit faulty.
// R18: Line five requests system reset; faults block turn-on until corrected.
// R19: Card insertion briefly shows match, mismatch or empty.
// R20: Manual reset valid only if all mapped inputs run.
// R21: Shared reset turns nothing on until sibling off-delay expires.
// R22: Monitored reset on falling edge after high of 0.3 to 2 seconds.
// R23: Non-monitored reset after high held 0.3 seconds.
// R24: Run-stop-run on manual-reset input latches mapped outputs off.
// R25: All timing by counters on one clock; reset returns states to off.
package sosr_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_OUT = 3;
    localparam int NUM_IN  = 8;
    localparam int IDX_W   = 3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ        = 25000000;
    localparam longint SCROLL_MS     = 2000;
    localparam longint RST_MIN_MS    = 300;
    localparam longint RST_MAX_MS    = 2000;
    localparam longint CARD_SHOW_MS  = 3000;
    localparam longint SCROLL_CYC    = CLK_HZ * SCROLL_MS / 1000;
    localparam longint RST_MIN_CYC   = (CLK_HZ * RST_MIN_MS + 999) / 1000;
    localparam longint RST_MAX_CYC   = CLK_HZ * RST_MAX_MS / 1000;
    localparam longint CARD_SHOW_CYC = CLK_HZ * CARD_SHOW_MS / 1000;
    localparam int     CNT_W         = 27;

    // ------------------------------------------------------------------
    // Output states and line five messages
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SO_OFF, SO_ON_DLY, SO_ON, SO_OFF_DLY, SO_RST_NEED, SO_FAULT, SO_ENABLE
    } sosr_out_st_t;

    typedef enum logic [3:0] {
        L5_NONE, L5_STOP, L5_TEST, L5_DEACT, L5_IN_FAULT, L5_TIMED_OUT,
        L5_VALVE_TEST, L5_RST_INPUT, L5_MON_FAULT, L5_ENABLE_MODE,
        L5_MUTE_LAMP, L5_SYS_RST, L5_MUTED, L5_BYPASSED
    } sosr_l5_t;

    typedef enum logic [1:0] {
        CARD_NONE, CARD_MATCH, CARD_DIFF, CARD_EMPTY
    } sosr_card_t;

    localparam logic [7:0] LINE1_NOT_CONF = 8'hFF;

endpackage : sosr_pkg

// *** rtl/sosr_top.sv ***
// Purpose: Safety output state tracking, status display and reset rules.
// Assumes: Inputs synchronous to CORE_CLK_I; input conditions pre-decoded.
// Notes:   Display lines carry codes; glyph rendering happens elsewhere.
`timescale 1ns/1ns
module sosr_top (
    // Clock and reset
    input  wire logic                    CORE_CLK_I,
    input  wire logic                    RST_I,
    // Per-input conditions, one bit per safety input; the map holds eight bits per output
    input  wire logic [7:0]              IN_RUN_I,
    input  wire logic [7:0]              IN_FAULT_I,
    input  wire logic [7:0]              IN_STARTUP_TEST_I,
    input  wire logic [7:0]              IN_CYCLE_NEED_I,
    input  wire logic [7:0]              IN_MANUAL_RST_I,
    input  wire logic [7:0]              IN_MUTED_I,
    input  wire logic [7:0]              IN_BYPASSED_I,
    input  wire logic [23:0]             IN_MAP_I,
    // Per-output conditions
    input  wire logic [2:0]              DLY_ON_EN_I,
    input  wire logic [2:0]              DLY_OFF_EN_I,
    input  wire logic [2:0]              DLY_ON_DONE_I,
    input  wire logic [2:0]              DLY_OFF_DONE_I,
    input  wire logic [2:0]              OUT_FAULT_I,
    input  wire logic [2:0]              MON_FAULT_I,
    input  wire logic [2:0]              ENABLE_MODE_I,
    input  wire logic [2:0]              ENABLE_EXPIRED_I,
    input  wire logic [2:0]              VALVE_TEST_I,
    input  wire logic [2:0]              RST_SHARE_I,
    // Reset sources and configuration
    input  wire logic                    MAN_RST_PIN_I,
    input  wire logic                    MAN_RST_MONITORED_I,
    input  wire logic                    SYS_RST_PIN_I,
    input  wire logic                    SYS_RST_MONITORED_I,
    input  wire logic                    SYS_RST_NEED_I,
    // Display and card
    input  wire logic                    CONF_OK_I,
    input  wire logic [7:0]              CONF_NAME_I,
    input  wire logic                    MUTE_LAMP_FAULT_I,
    input  wire logic                    BTN_UP_I,
    input  wire logic                    BTN_DOWN_I,
    input  wire logic                    CARD_INSERT_I,
    input  wire logic                    CARD_HAS_CONF_I,
    input  wire logic                    CARD_MATCH_I,
    // Outputs
    output logic [2:0]                   SAFETY_ON_O,
    output logic [7:0]                   LINE1_O,
    output logic [8:0]                   LINE234_O,
    output logic [1:0]                   MARKER_O,
    output logic [3:0]                   LINE5_MSG_O,
    output logic [2:0]                   LINE5_IDX_O,
    output logic [1:0]                   CARD_MSG_O
);

    typedef struct packed {
        logic [2:0][2:0]                 st;
        logic [2:0]                      latch_off;
        logic [7:0]                      prev_run;
        logic [7:0]                      seen_stop;
        logic [1:0]                      marker;
        logic [2:0]                      in_idx;
        logic                            frozen;
        logic [26:0]                     scroll_cnt;
        logic                            man_prev;
        logic [26:0]                     man_cnt;
        logic                            man_done;
        logic                            sys_prev;
        logic [26:0]                     sys_cnt;
        logic                            sys_done;
        logic                            card_prev;
        logic [1:0]                      card;
        logic [26:0]                     card_cnt;
        logic [2:0]                      on;
        logic [7:0]                      line1;
        logic [8:0]                      line234;
        logic [3:0]                      l5;
        logic [2:0]                      l5_idx;
    } sosr_state_t;

    sosr_state_t s_q;
    sosr_state_t s_d;

    localparam logic [26:0] SCROLL_C  = 27'(sosr_pkg::SCROLL_CYC);
    localparam logic [26:0] RMIN_C    = 27'(sosr_pkg::RST_MIN_CYC);
    localparam logic [26:0] RMAX_C    = 27'(sosr_pkg::RST_MAX_CYC);
    localparam logic [26:0] CARD_C    = 27'(sosr_pkg::CARD_SHOW_CYC);

    // Combinational helper terms derived from the inputs and the registered state.
    logic [2:0] blocked;
    logic [2:0] all_run;
    logic [2:0] info_on;
    logic [2:0] any_off;
    logic       man_ev;
    logic       sys_ev;
    logic [7:0] cause_vec;
    logic [7:0] want_off;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // A single process computes the whole next state so ordering between
    // reset events, latches and display selection stays explicit.
    always_comb begin
        logic [7:0]       m;
        logic [2:0]       nx;
        logic             hit;
        sosr_pkg::sosr_l5_t msg;
        s_d       = s_q;
        m         = 8'h00;
        nx        = 3'h0;
        hit       = 1'b0;
        msg       = sosr_pkg::L5_NONE;
        blocked   = 3'h0;
        all_run   = 3'h0;
        info_on   = 3'h0;
        any_off   = 3'h0;
        cause_vec = 8'h00;
        want_off  = 8'h00;

        // Manual reset pulse qualification.
        s_d.man_prev = MAN_RST_PIN_I;
        s_d.man_done = 1'b0;
        if (MAN_RST_PIN_I) begin
            if (s_q.man_cnt != 27'h7FFFFFF) begin
                s_d.man_cnt = s_q.man_cnt + 27'h0000001;
            end
        end else begin
            s_d.man_cnt = 27'h0000000;
        end
        if (MAN_RST_MONITORED_I) begin
            s_d.man_done = s_q.man_prev && !MAN_RST_PIN_I &&
                           s_q.man_cnt >= RMIN_C &&
                           s_q.man_cnt <= RMAX_C; // R22
        end else begin
            s_d.man_done = MAN_RST_PIN_I &&
                           s_q.man_cnt == RMIN_C - 27'h0000001; // R23
        end
        man_ev = s_q.man_done;

        // System reset pulse qualification, same timing rules.
        s_d.sys_prev = SYS_RST_PIN_I;
        if (SYS_RST_PIN_I) begin
            if (s_q.sys_cnt != 27'h7FFFFFF) begin
                s_d.sys_cnt = s_q.sys_cnt + 27'h0000001;
            end
        end else begin
            s_d.sys_cnt = 27'h0000000;
        end
        if (SYS_RST_MONITORED_I) begin
            s_d.sys_done = s_q.sys_prev && !SYS_RST_PIN_I &&
                           s_q.sys_cnt >= RMIN_C &&
                           s_q.sys_cnt <= RMAX_C; // R22
        end else begin
            s_d.sys_done = SYS_RST_PIN_I &&
                           s_q.sys_cnt == RMIN_C - 27'h0000001; // R23
        end
        sys_ev = s_q.sys_done;

        // Run-stop-run tracking per input; a stop arms the cycle flag.
        s_d.prev_run = IN_RUN_I;
        for (int i = 0; i < 8; i++) begin
            if (!IN_RUN_I[i]) begin
                s_d.seen_stop[i] = 1'b1;
            end else if (s_q.seen_stop[i] && s_q.prev_run[i]) begin
                s_d.seen_stop[i] = 1'b0;
            end
        end

        // Per-output evaluation.
        for (int o = 0; o < 3; o++) begin
            for (int i = 0; i < 8; i++) begin
                m[i] = IN_MAP_I[o*8+i];
            end
            all_run[o] = ((m & ~IN_RUN_I) == 8'h00); // R20
            blocked[o] = |(m & (~IN_RUN_I | IN_FAULT_I)) ||  // R11
                         |(m & IN_STARTUP_TEST_I) ||          // R12
                         |(m & IN_CYCLE_NEED_I) ||            // R13
                         VALVE_TEST_I[o] ||                   // R15
                         ENABLE_EXPIRED_I[o];                 // R14
            info_on[o] = |(m & (IN_MUTED_I | IN_BYPASSED_I |
                                IN_FAULT_I));                 // R16
            // Run-stop-run on a manual-reset input latches the output off.
            if (|(m & IN_MANUAL_RST_I & IN_RUN_I & ~s_q.prev_run)) begin
                s_d.latch_off[o] = 1'b1; // R24
            end else if (man_ev && all_run[o] &&
                         !(|(RST_SHARE_I & DLY_OFF_EN_I &
                             ~DLY_OFF_DONE_I))) begin
                s_d.latch_off[o] = 1'b0; // R21
            end

            case (sosr_pkg::sosr_out_st_t'(s_q.st[o]))
                sosr_pkg::SO_OFF: begin
                    if (s_d.latch_off[o] && !blocked[o]) begin
                        nx = 3'(sosr_pkg::SO_RST_NEED); // R6
                    end else if (!blocked[o] && !SYS_RST_NEED_I) begin
                        nx = DLY_ON_EN_I[o] ? 3'(sosr_pkg::SO_ON_DLY)
                                            : 3'(sosr_pkg::SO_ON);
                    end else begin
                        nx = s_q.st[o];
                    end
                end
                sosr_pkg::SO_ON_DLY: begin
                    nx = blocked[o] ? 3'(sosr_pkg::SO_OFF) :
                         DLY_ON_DONE_I[o] ? 3'(sosr_pkg::SO_ON)
                                          : s_q.st[o]; // R5
                end
                sosr_pkg::SO_ON: begin
                    if (blocked[o] || s_q.latch_off[o]) begin
                        nx = DLY_OFF_EN_I[o] ? 3'(sosr_pkg::SO_OFF_DLY)
                                             : 3'(sosr_pkg::SO_OFF);
                    end else begin
                        nx = s_q.st[o];
                    end
                end
                sosr_pkg::SO_OFF_DLY: begin
                    nx = DLY_OFF_DONE_I[o] ? 3'(sosr_pkg::SO_OFF)
                                           : s_q.st[o]; // R5
                end
                sosr_pkg::SO_RST_NEED: begin
                    nx = !s_d.latch_off[o] ? 3'(sosr_pkg::SO_OFF)
                                           : s_q.st[o];
                end
                sosr_pkg::SO_FAULT: begin
                    // Fault stays until corrected and a system reset, or until corrected with enable mode set.
                    nx = (sys_ev && !OUT_FAULT_I[o] && !MON_FAULT_I[o])
                         ? 3'(sosr_pkg::SO_OFF) : s_q.st[o]; // R8
                end
                sosr_pkg::SO_ENABLE: begin
                    nx = (sys_ev && !(|(m & IN_RUN_I)))
                         ? 3'(sosr_pkg::SO_OFF) : s_q.st[o]; // R14
                end
                default: begin
                    nx = 3'(sosr_pkg::SO_OFF);
                end
            endcase
            if (OUT_FAULT_I[o] || MON_FAULT_I[o]) begin
                nx = 3'(sosr_pkg::SO_FAULT); // R18
            end else if (ENABLE_MODE_I[o] &&
                         s_q.st[o] != 3'(sosr_pkg::SO_ENABLE)) begin
                nx = 3'(sosr_pkg::SO_ENABLE);
            end
            s_d.st[o] = nx;
            s_d.on[o] = (nx == 3'(sosr_pkg::SO_ON)) ||
                        (nx == 3'(sosr_pkg::SO_OFF_DLY)) ||
                        (nx == 3'(sosr_pkg::SO_ENABLE) &&
                         !ENABLE_EXPIRED_I[o]);
            any_off[o] = (s_q.st[o] != 3'(sosr_pkg::SO_ON)) &&
                         (s_q.st[o] != 3'(sosr_pkg::SO_ON_DLY));
        end

        // Lines one to four.
        s_d.line1   = CONF_OK_I ? CONF_NAME_I
                                : sosr_pkg::LINE1_NOT_CONF; // R1
        s_d.line234 = s_q.st; // R2

        // Marker steps through off outputs every scroll period; the
        // same tick rotates the input shown on line five.
        s_d.scroll_cnt = s_q.scroll_cnt + 27'h0000001;
        if (s_q.scroll_cnt >= SCROLL_C - 27'h0000001) begin
            s_d.scroll_cnt = 27'h0000000;
            hit = 1'b1;
        end
        if (hit) begin
            if (any_off[(s_q.marker + 2'h1) % 3]) begin
                s_d.marker = 2'((s_q.marker + 2'h1) % 3); // R3
            end else if (any_off[(s_q.marker + 2'h2) % 3]) begin
                s_d.marker = 2'((s_q.marker + 2'h2) % 3); // R3
            end
        end
        if (s_q.marker > 2'h2) begin
            s_d.marker = 2'h0;
        end

        // Causes for the marked output, mapped inputs only.
        for (int i = 0; i < 8; i++) begin
            m[i] = IN_MAP_I[s_q.marker*8+i];
        end
        want_off  = m & (~IN_RUN_I | IN_FAULT_I | IN_STARTUP_TEST_I |
                         IN_CYCLE_NEED_I | IN_MUTED_I | IN_BYPASSED_I);
        cause_vec = want_off;
        if (BTN_UP_I) begin
            s_d.frozen = 1'b1; // R10
        end
        if ((hit && !s_q.frozen) || BTN_DOWN_I) begin
            s_d.in_idx = s_q.in_idx + 3'h1; // R10
            for (int k = 7; k >= 1; k--) begin
                if (cause_vec[3'(s_q.in_idx + 3'(k))]) begin
                    s_d.in_idx = 3'(s_q.in_idx + 3'(k));
                end
            end
        end

        // Line five priority: lamp, output-level causes, inputs.
        case (sosr_pkg::sosr_out_st_t'(s_q.st[s_q.marker]))
            sosr_pkg::SO_RST_NEED: msg = sosr_pkg::L5_RST_INPUT;      // R6
            sosr_pkg::SO_FAULT:
                msg = MON_FAULT_I[s_q.marker] ? sosr_pkg::L5_MON_FAULT
                                              : sosr_pkg::L5_IN_FAULT; // R7
            sosr_pkg::SO_ENABLE:
                msg = ENABLE_EXPIRED_I[s_q.marker]
                      ? sosr_pkg::L5_TIMED_OUT
                      : sosr_pkg::L5_ENABLE_MODE;                     // R14
            default: msg = sosr_pkg::L5_NONE;
        endcase
        if (msg == sosr_pkg::L5_NONE &&
            (any_off[s_q.marker] || info_on[s_q.marker])) begin
            if (VALVE_TEST_I[s_q.marker]) begin
                msg = sosr_pkg::L5_VALVE_TEST;                        // R15
            end else if (cause_vec[s_q.in_idx]) begin
                if (IN_FAULT_I[s_q.in_idx]) begin
                    msg = sosr_pkg::L5_IN_FAULT;
                end else if (!IN_RUN_I[s_q.in_idx]) begin
                    msg = sosr_pkg::L5_STOP;                          // R9
                end else if (IN_STARTUP_TEST_I[s_q.in_idx]) begin
                    msg = sosr_pkg::L5_TEST;
                end else if (IN_CYCLE_NEED_I[s_q.in_idx]) begin
                    msg = sosr_pkg::L5_DEACT;
                end else if (IN_MUTED_I[s_q.in_idx]) begin
                    msg = sosr_pkg::L5_MUTED;                         // R16
                end else begin
                    msg = sosr_pkg::L5_BYPASSED;
                end
            end else if (SYS_RST_NEED_I) begin
                msg = sosr_pkg::L5_SYS_RST;                           // R18
            end
        end
        if (MUTE_LAMP_FAULT_I) begin
            msg = sosr_pkg::L5_MUTE_LAMP;                             // R17
        end
        s_d.l5     = msg;
        s_d.l5_idx = (msg == sosr_pkg::L5_RST_INPUT ||
                      msg == sosr_pkg::L5_MON_FAULT) ? 3'(s_q.marker)
                                                     : s_q.in_idx;    // R4

        // Card result shows for a fixed time after insertion.
        s_d.card_prev = CARD_INSERT_I;
        if (CARD_INSERT_I && !s_q.card_prev) begin
            s_d.card     = !CARD_HAS_CONF_I ? 2'(sosr_pkg::CARD_EMPTY) :
                           CARD_MATCH_I     ? 2'(sosr_pkg::CARD_MATCH)
                                            : 2'(sosr_pkg::CARD_DIFF); // R19
            s_d.card_cnt = CARD_C;
        end else if (s_q.card_cnt != 27'h0000000) begin
            s_d.card_cnt = s_q.card_cnt - 27'h0000001;
        end else begin
            s_d.card = 2'(sosr_pkg::CARD_NONE);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset puts every output in off and clears all counters.
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s_q          <= '0; // R25
            s_q.prev_run <= 8'hFF; // Idle run level, so no false edge.
        end else begin
            s_q <= s_d; // R25
        end
    end

    // Outputs straight from the state flip-flops.
    assign SAFETY_ON_O = s_q.on;
    assign LINE1_O     = s_q.line1;
    assign LINE234_O   = s_q.line234;
    assign MARKER_O    = s_q.marker;
    assign LINE5_MSG_O = s_q.l5;
    assign LINE5_IDX_O = s_q.l5_idx;
    assign CARD_MSG_O  = s_q.card;

endmodule : sosr_top

// *** verif/sosr_button_model.sv ***
// Purpose: Reset button model driving the manual reset pin.
// Assumes: The pin has a pull-down, so a released button reads low.
// Notes:   Press length is in core clock cycles.
`timescale 1ns/1ns
module sosr_button_model (
    input  wire logic        clk_i,
    input  wire logic        press_i,
    input  wire logic [15:0] len_i,
    output logic             pin_o
);
    logic [15:0] cnt_q = 16'h0000;
    // A press holds the line high for len_i cycles, then it is released.
    always @(posedge clk_i) begin
        if (press_i)
            cnt_q <= len_i;
        else if (cnt_q != 16'h0000)
            cnt_q <= cnt_q - 16'h0001;
    end
    assign pin_o = (cnt_q != 16'h0000);
endmodule : sosr_button_model

// *** verif/sosr_top_assertions.sv ***
// Purpose: Port checks for the safety output status block.
// Assumes: Outputs settle within two cycles of a held input.
// Notes:   Held inputs are required so that pipeline lag never misfires.
`timescale 1ns/1ns
module sosr_checker (
    input wire logic       CORE_CLK_I, RST_I, CONF_OK_I, CARD_INSERT_I,
    input wire logic       CARD_HAS_CONF_I, CARD_MATCH_I,
    input wire logic [7:0] IN_RUN_I, CONF_NAME_I, LINE1_O,
    input wire logic [23:0] IN_MAP_I,
    input wire logic [2:0] DLY_OFF_EN_I, ENABLE_MODE_I, OUT_FAULT_I,
    input wire logic [2:0] VALVE_TEST_I, SAFETY_ON_O,
    input wire logic [8:0] LINE234_O,
    input wire logic [1:0] CARD_MSG_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // Three held cycles cover the two-cycle pipeline.
    sequence s_card_in;
        $rose(CARD_INSERT_I) && CARD_HAS_CONF_I && CARD_MATCH_I;
    endsequence
    property p_name;
        (CONF_OK_I && $stable(CONF_NAME_I))[*3] |-> LINE1_O == CONF_NAME_I;
    endproperty
    property p_noconf;
        (!CONF_OK_I)[*3] |-> LINE1_O == sosr_pkg::LINE1_NOT_CONF;
    endproperty
    property p_stop;
        (|(IN_MAP_I[7:0] & ~IN_RUN_I) && !DLY_OFF_EN_I[0]
            && !ENABLE_MODE_I[0])[*3] |-> !SAFETY_ON_O[0];
    endproperty
    property p_fault;
        OUT_FAULT_I[0][*3] |->
            !SAFETY_ON_O[0] && LINE234_O[2:0] == sosr_pkg::SO_FAULT;
    endproperty
    property p_valve;
        VALVE_TEST_I[0][*3] |-> !SAFETY_ON_O[0];
    endproperty
    property p_onst;
        SAFETY_ON_O[0] |=> LINE234_O[2:0] inside
            {sosr_pkg::SO_ON, sosr_pkg::SO_OFF_DLY, sosr_pkg::SO_ENABLE};
    endproperty
    property p_card;
        s_card_in |-> ##[1:3] CARD_MSG_O == sosr_pkg::CARD_MATCH;
    endproperty
    property p_rst;
        disable iff (1'b0) RST_I |-> SAFETY_ON_O == 3'h0 && LINE234_O == 9'h000;
    endproperty
    a_name: assert property (p_name) else $error("line one name");
    a_noconf: assert property (p_noconf) else $error("line one code");
    a_stop: assert property (p_stop) else $error("stop left on");
    a_fault: assert property (p_fault) else $error("fault not shown");
    a_valve: assert property (p_valve) else $error("valve test on");
    a_onst: assert property (p_onst) else $error("on state mismatch");
    a_card: assert property (p_card) else $error("card msg missing");
    a_rst: assert property (p_rst) else $error("reset not off");
endmodule : sosr_checker
bind sosr_top sosr_checker u_sosr_checker (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .CONF_OK_I(CONF_OK_I),
    .CARD_INSERT_I(CARD_INSERT_I), .CARD_HAS_CONF_I(CARD_HAS_CONF_I),
    .CARD_MATCH_I(CARD_MATCH_I), .IN_RUN_I(IN_RUN_I), .IN_MAP_I(IN_MAP_I),
    .CONF_NAME_I(CONF_NAME_I), .LINE1_O(LINE1_O), .DLY_OFF_EN_I(DLY_OFF_EN_I),
    .ENABLE_MODE_I(ENABLE_MODE_I), .OUT_FAULT_I(OUT_FAULT_I),
    .VALVE_TEST_I(VALVE_TEST_I), .SAFETY_ON_O(SAFETY_ON_O),
    .LINE234_O(LINE234_O), .CARD_MSG_O(CARD_MSG_O));

// *** verif/sosr_top_tb.sv ***
// Purpose: Scenario bench for the safety output status block.
// Assumes: Input 0 feeds output 0, input 1 feeds output 1.
// Notes:   Reset pulse lengths of 0.3 s are out of reach; short ones are not.
`timescale 1ns/1ns
module sosr_top_tb;
    logic clk = 1'b0, rst = 1'b0, man_pin;
    logic [7:0] run = 8'hFF, name = 8'h00, flt, tst, cyn, mrs, mut, byp, l1;
    logic [23:0] map = 24'h000201;
    logic [2:0] don, dof, dond, dofd, ofl, mfl, enm, enx, vlv, shr, son, l5i;
    logic mrm, srp, srm, srn, cok, mlf, bup, bdn, cin, chc, cmt, press;
    logic [8:0] l234;
    logic [3:0] l5m;
    logic [1:0] mk, cm;
    int fail_count = 0, cmp_count = 0;
    always #20 clk = ~clk;
    sosr_button_model u_sosr_button_model (.clk_i(clk), .press_i(press),
        .len_i(16'h0064), .pin_o(man_pin));
    sosr_top u_sosr_top (
        .CORE_CLK_I(clk), .RST_I(rst), .IN_RUN_I(run), .IN_FAULT_I(flt),
        .IN_STARTUP_TEST_I(tst), .IN_CYCLE_NEED_I(cyn), .IN_MANUAL_RST_I(mrs),
        .IN_MUTED_I(mut), .IN_BYPASSED_I(byp), .IN_MAP_I(map),
        .DLY_ON_EN_I(don), .DLY_OFF_EN_I(dof), .DLY_ON_DONE_I(dond),
        .DLY_OFF_DONE_I(dofd), .OUT_FAULT_I(ofl), .MON_FAULT_I(mfl),
        .ENABLE_MODE_I(enm), .ENABLE_EXPIRED_I(enx), .VALVE_TEST_I(vlv),
        .RST_SHARE_I(shr), .MAN_RST_PIN_I(man_pin), .MAN_RST_MONITORED_I(mrm),
        .SYS_RST_PIN_I(srp), .SYS_RST_MONITORED_I(srm), .SYS_RST_NEED_I(srn),
        .CONF_OK_I(cok), .CONF_NAME_I(name), .MUTE_LAMP_FAULT_I(mlf),
        .BTN_UP_I(bup), .BTN_DOWN_I(bdn), .CARD_INSERT_I(cin),
        .CARD_HAS_CONF_I(chc), .CARD_MATCH_I(cmt), .SAFETY_ON_O(son),
        .LINE1_O(l1), .LINE234_O(l234), .MARKER_O(mk), .LINE5_MSG_O(l5m),
        .LINE5_IDX_O(l5i), .CARD_MSG_O(cm));
    task automatic tick(int n);
        repeat (n) @(posedge clk);
    endtask : tick
    task automatic finish_test();
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // Outputs are judged at the falling edge, where they have settled.
    task automatic chk(logic [8:0] got, logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // A bounded wait, so a stuck output ends the run instead of hanging it.
    task automatic wait_on(int o, logic e);
        for (int i = 0; i < 20 && son[o] !== e; i++) @(negedge clk);
        chk({8'h00, son[o]}, {8'h00, e});
        if (son[o] !== e) finish_test();
    endtask : wait_on
    task automatic t_line1();
        @(posedge clk); cok <= 1'b0; tick(4); @(negedge clk);
        chk({1'b0, l1}, {1'b0, sosr_pkg::LINE1_NOT_CONF});
        @(posedge clk); cok <= 1'b1; name <= 8'h5A; tick(4); @(negedge clk);
        chk({1'b0, l1}, 9'h05A);
    endtask : t_line1
    task automatic t_run();
        @(posedge clk); wait_on(0, 1'b1);
        chk({6'h00, l234[2:0]}, {6'h00, sosr_pkg::SO_ON});
        @(posedge clk); run[0] <= 1'b0; wait_on(0, 1'b0);
        @(negedge clk);
        chk({6'h00, l234[2:0]}, {6'h00, sosr_pkg::SO_OFF});
        chk({l5i, mk, l5m}, {5'h00, sosr_pkg::L5_STOP});
        @(posedge clk); run[0] <= 1'b1; wait_on(0, 1'b1);
        @(posedge clk); vlv[0] <= 1'b1; wait_on(0, 1'b0);
        @(posedge clk); vlv[0] <= 1'b0; wait_on(0, 1'b1);
    endtask : t_run
    // A cleared fault must still wait for a system reset.
    task automatic t_fault();
        @(posedge clk); ofl[0] <= 1'b1; wait_on(0, 1'b0);
        @(negedge clk);
        chk({6'h00, l234[2:0]}, {6'h00, sosr_pkg::SO_FAULT});
        @(posedge clk); ofl[0] <= 1'b0; tick(6); @(negedge clk);
        chk({8'h00, son[0]}, 9'h000);
        @(posedge clk); chc <= 1'b1; cmt <= 1'b1; cin <= 1'b1; tick(4);
        @(negedge clk);
        chk({7'h00, cm}, {7'h00, sosr_pkg::CARD_MATCH});
        @(posedge clk); rst <= 1'b1; tick(2); @(negedge clk);
        chk({6'h00, son}, 9'h000);
        @(posedge clk); rst <= 1'b0;
    endtask : t_fault
    // Run-stop-run latches output 1; a too short press must not free it.
    task automatic t_latch();
        @(posedge clk); mrs[1] <= 1'b1; tick(3); run[1] <= 1'b0;
        tick(3); run[1] <= 1'b1; tick(4); @(negedge clk);
        chk({5'h00, son[1], l234[5:3]}, {6'h00, sosr_pkg::SO_RST_NEED});
        @(posedge clk); press <= 1'b1; @(posedge clk); press <= 1'b0;
        tick(200); @(negedge clk);
        chk({5'h00, son[1], l234[5:3]}, {6'h00, sosr_pkg::SO_RST_NEED});
    endtask : t_latch
    initial begin
        {don, dof, dond, dofd, ofl, mfl, enm, enx, vlv, shr} = '0;
        {mrm, srp, srm, srn, cok, mlf, bup, bdn, cin, chc, cmt, press} = '0;
        {flt, tst, cyn, mrs, mut, byp} = '0;
        #1 rst = 1'b1;
        tick(5);
        rst <= 1'b0;
        t_line1();
        t_run();
        t_fault();
        t_latch();
        finish_test();
    end
endmodule : sosr_top_tb
